// [core/psb_regs.sv]
/*
 Register bank for system monitor, hibernate and first buck converter,
 reached through a two-wire serial slave (sda open drain).
 Assumes analog blocks give comparator/fault/power-good levels asynchronously.
*/
// Behaviour
// - Time-out bit picks 65 ms (one) or 260 ms (zero) reset out.
// - Monitor response one raises interrupt, zero forces automatic shutdown.
// - System-voltage interrupt masked at reset; writing one unmasks it.
// - Status bit reads one while supply below threshold.
// - Four-bit threshold field drives detector trip level.
// - Force-on keeps converter running during hibernate without power hold.
// - User bits store writes only; cleared by undervoltage lockout.
// - Host-written hibernate-ready flag tells wake from hibernate versus cold.
// - Primary set point drives output when select pin low.
// - Secondary set point drives output when select pin high.
// - Enable bit turns converter on or off.
// - Phase bit selects 180 degrees out of phase or in phase.
// - Mode bit forces fixed-frequency PWM; zero allows power saving.
// - Three-bit turn-on delay field read/write, drives sequencer delay.
// - Fault unmask bit enables converter fault interrupts.
// - Power-good bit reads converter output above its threshold.
`timescale 1ns/1ps
module psb_regs #(
	parameter logic [6:0] DEV_ADDR = psb_pkg::DEV_ADDR_DFLT,
	parameter int unsigned RST_SHORT_CYC = psb_pkg::RST_SHORT_MS * psb_pkg::CYC_PER_MS,
	parameter int unsigned RST_LONG_CYC = psb_pkg::RST_LONG_MS * psb_pkg::CYC_PER_MS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic sysvolt_low_in,
	input wire logic buck1_fault_in,
	input wire logic buck1_pgood_in,
	input wire logic setpoint_select_pin,
	input wire logic power_hold_in,
	input wire logic uvlo_in,
	output logic [3:0] sysvolt_threshold,
	output logic buck1_en,
	output logic [5:0] buck1_vout_code,
	output logic buck1_phase,
	output logic buck1_pwm_force,
	output logic [2:0] buck1_delay,
	output logic auto_shutdown,
	output logic irq_n,
	output logic reset_out_pin_n
);
	logic [psb_pkg::NSYNC-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
	logic [psb_pkg::NSYNC-1:0] nxt_filt;
	logic scl_prev_ff, sda_prev_ff;
	logic scl_s, sda_s, low_s, flt_s, pg_s, setpoint_select_pin_s, hold_s, uvlo_s;
	logic scl_rise, scl_fall, start_c, stop_c;

	// Three stages; value accepted once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < psb_pkg::NSYNC; gi++)
		begin : g_sync
			assign nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : filt_ff[gi];
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			// Whole chain idles high; lockout lane holds the bank until real pins arrive
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
			filt_ff <= '1;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end
		else
		begin
			s1_ff <= {uvlo_in, power_hold_in, setpoint_select_pin, buck1_pgood_in,
				buck1_fault_in, sysvolt_low_in, sda_in, scl_in};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			filt_ff <= nxt_filt;
			scl_prev_ff <= filt_ff[psb_pkg::SI_SCL];
			sda_prev_ff <= filt_ff[psb_pkg::SI_SDA];
		end
	end

	assign scl_s = filt_ff[psb_pkg::SI_SCL];
	assign sda_s = filt_ff[psb_pkg::SI_SDA];
	assign low_s = filt_ff[psb_pkg::SI_LOW];
	assign flt_s = filt_ff[psb_pkg::SI_FLT];
	assign pg_s = filt_ff[psb_pkg::SI_PG];
	assign setpoint_select_pin_s = filt_ff[psb_pkg::SI_SETPOINT_SELECT_PIN];
	assign hold_s = filt_ff[psb_pkg::SI_HOLD];
	assign uvlo_s = filt_ff[psb_pkg::SI_UVLO];
	assign scl_rise = scl_s & ~scl_prev_ff;
	assign scl_fall = ~scl_s & scl_prev_ff;
	assign start_c = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
	assign stop_c = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

	psb_pkg::psb_sysmon_t sysmon_ff, nxt_sysmon;
	psb_pkg::psb_hib_t hib_ff, nxt_hib;
	psb_pkg::psb_ctrl_t ctrl_ff, nxt_ctrl;
	logic [5:0] sp1_ff, sp2_ff, nxt_sp1, nxt_sp2;
	logic wr_en;
	logic [7:0] ptr_ff, nxt_ptr, sh_ff, nxt_sh;

	// Read mux, shared by first byte and follow-on bytes
	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		logic [7:0] d;
		d = psb_pkg::BYTE_ZERO;
		case (a)
			psb_pkg::ADDR_SYSMON: d = {sysmon_ff.short_rst_sel, sysmon_ff.monitor_response_sel,
				sysmon_ff.sysvolt_irq_unmask, low_s, sysmon_ff.sysvolt_threshold};
			psb_pkg::ADDR_HIB: d = hib_ff;
			psb_pkg::ADDR_SP1: d = {2'b00, sp1_ff};
			psb_pkg::ADDR_SP2: d = {2'b00, sp2_ff};
			psb_pkg::ADDR_CTRL: d = {ctrl_ff, pg_s};
			default: d = psb_pkg::BYTE_ZERO;
		endcase
		return d;
	endfunction : rd_byte

	// Register group
	always_comb
	begin
		nxt_sysmon = sysmon_ff;
		nxt_hib = hib_ff;
		nxt_ctrl = ctrl_ff;
		nxt_sp1 = sp1_ff;
		nxt_sp2 = sp2_ff;
		if (uvlo_s)
		begin
			nxt_sysmon = psb_pkg::SYSMON_RST;
			nxt_hib = psb_pkg::HIB_RST;
			nxt_ctrl = psb_pkg::CTRL_RST;
			nxt_sp1 = psb_pkg::SP1_RST;
			nxt_sp2 = psb_pkg::SP2_RST;
		end
		else if (wr_en)
		begin
			case (ptr_ff)
				psb_pkg::ADDR_SYSMON: nxt_sysmon = {sh_ff[7:5], sh_ff[3:0]};
				psb_pkg::ADDR_HIB: nxt_hib = sh_ff;
				psb_pkg::ADDR_SP1: nxt_sp1 = sh_ff[5:0];
				psb_pkg::ADDR_SP2: nxt_sp2 = sh_ff[5:0];
				psb_pkg::ADDR_CTRL: nxt_ctrl = sh_ff[7:1];
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sysmon_ff <= psb_pkg::SYSMON_RST;
			hib_ff <= psb_pkg::HIB_RST;
			ctrl_ff <= psb_pkg::CTRL_RST;
			sp1_ff <= psb_pkg::SP1_RST;
			sp2_ff <= psb_pkg::SP2_RST;
		end
		else
		begin
			sysmon_ff <= nxt_sysmon;
			hib_ff <= nxt_hib;
			ctrl_ff <= nxt_ctrl;
			sp1_ff <= nxt_sp1;
			sp2_ff <= nxt_sp2;
		end
	end

	// Serial slave group
	psb_pkg::psb_state_t state_ff, nxt_state;
	psb_pkg::psb_phase_t phase_ff, nxt_phase;
	logic [3:0] cnt_ff, nxt_cnt;
	logic rd_ff, nxt_rd, oe_ff, nxt_oe;

	always_comb
	begin
		logic [7:0] nb;
		nb = rd_byte(ptr_ff + psb_pkg::PTR_STEP);
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_cnt = cnt_ff;
		nxt_rd = rd_ff;
		nxt_oe = oe_ff;
		nxt_sh = sh_ff;
		nxt_ptr = ptr_ff;
		wr_en = 1'b0;
		if (start_c)
		begin
			nxt_state = psb_pkg::ST_RX;
			nxt_phase = psb_pkg::PH_ADDR;
			nxt_cnt = psb_pkg::BIT_ZERO;
			nxt_oe = 1'b0;
		end
		else if (stop_c)
		begin
			nxt_state = psb_pkg::ST_IDLE;
			nxt_oe = 1'b0;
		end
		else
		begin
			case (state_ff)
				psb_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						nxt_sh = {sh_ff[6:0], sda_s};
						nxt_cnt = cnt_ff + psb_pkg::BIT_STEP;
					end
					else if (scl_fall && cnt_ff == psb_pkg::BIT_FULL)
					begin
						nxt_cnt = psb_pkg::BIT_ZERO;
						nxt_state = psb_pkg::ST_ACK;
						nxt_oe = 1'b1;
						if (phase_ff == psb_pkg::PH_ADDR)
						begin
							nxt_rd = sh_ff[0];
							nxt_phase = psb_pkg::PH_PTR;
							if (sh_ff[7:1] != DEV_ADDR)
							begin
								nxt_state = psb_pkg::ST_IDLE;
								nxt_oe = 1'b0;
							end
						end
						else if (phase_ff == psb_pkg::PH_PTR)
						begin
							nxt_ptr = sh_ff;
							nxt_phase = psb_pkg::PH_DATA;
						end
						else
						begin
							wr_en = 1'b1;
							nxt_ptr = ptr_ff + psb_pkg::PTR_STEP;
						end
					end
				end
				psb_pkg::ST_ACK:
				begin
					if (scl_fall)
					begin
						nxt_oe = 1'b0;
						nxt_state = psb_pkg::ST_RX;
						if (rd_ff)
						begin
							nxt_sh = rd_byte(ptr_ff);
							nxt_oe = ~nxt_sh[7];
							nxt_state = psb_pkg::ST_TX;
						end
					end
				end
				psb_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						nxt_cnt = cnt_ff + psb_pkg::BIT_STEP;
						nxt_sh = {sh_ff[6:0], 1'b0};
						nxt_oe = ~sh_ff[6];
						if (cnt_ff == psb_pkg::BIT_LAST)
						begin
							nxt_state = psb_pkg::ST_MACK;
							nxt_oe = 1'b0;
						end
					end
				end
				psb_pkg::ST_MACK:
				begin
					if (scl_rise && sda_s)
					begin
						nxt_state = psb_pkg::ST_IDLE;
					end
					else if (scl_fall)
					begin
						nxt_ptr = ptr_ff + psb_pkg::PTR_STEP;
						nxt_sh = nb;
						nxt_oe = ~nb[7];
						nxt_cnt = psb_pkg::BIT_ZERO;
						nxt_state = psb_pkg::ST_TX;
					end
				end
				default: nxt_state = psb_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_ff <= psb_pkg::ST_IDLE;
			phase_ff <= psb_pkg::PH_ADDR;
			cnt_ff <= psb_pkg::BIT_ZERO;
			rd_ff <= 1'b0;
			oe_ff <= 1'b0;
			sh_ff <= psb_pkg::BYTE_ZERO;
			ptr_ff <= psb_pkg::BYTE_ZERO;
		end
		else
		begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			cnt_ff <= nxt_cnt;
			rd_ff <= nxt_rd;
			oe_ff <= nxt_oe;
			sh_ff <= nxt_sh;
			ptr_ff <= nxt_ptr;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_ff;

	// Converter and monitor outputs group
	logic en_ff, nxt_en, shut_ff, nxt_shut, irq_n_ff, nxt_irq_n, rsto_n_ff, nxt_rsto_n;
	logic [5:0] vout_ff, nxt_vout;
	logic [psb_pkg::TMR_W-1:0] tmr_ff, nxt_tmr, tmr_end;

	always_comb
	begin
		tmr_end = sysmon_ff.short_rst_sel ? psb_pkg::TMR_W'(RST_SHORT_CYC - 1) : psb_pkg::TMR_W'(RST_LONG_CYC - 1);
		nxt_tmr = tmr_ff;
		nxt_rsto_n = rsto_n_ff;
		if (!pg_s)
		begin
			nxt_tmr = '0;
			nxt_rsto_n = 1'b0;
		end
		else if (!rsto_n_ff)
		begin
			nxt_tmr = tmr_ff + 1'b1;
			nxt_rsto_n = (tmr_ff == tmr_end);
		end
		nxt_shut = uvlo_s ? 1'b0 : (shut_ff | (low_s & ~sysmon_ff.monitor_response_sel));
		// enable bit, force-on overrides power hold
		nxt_en = ctrl_ff.on & ~shut_ff & (hold_s | hib_ff.buck1_force_on);
		nxt_vout = setpoint_select_pin_s ? sp2_ff : sp1_ff;
		nxt_irq_n = ~((low_s & sysmon_ff.monitor_response_sel & sysmon_ff.sysvolt_irq_unmask)
			| (flt_s & ctrl_ff.fault_irq_unmask));
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tmr_ff <= '0;
			rsto_n_ff <= 1'b0;
			shut_ff <= 1'b0;
			en_ff <= 1'b0;
			vout_ff <= psb_pkg::SP1_RST;
			irq_n_ff <= 1'b1;
		end
		else
		begin
			tmr_ff <= nxt_tmr;
			rsto_n_ff <= nxt_rsto_n;
			shut_ff <= nxt_shut;
			en_ff <= nxt_en;
			vout_ff <= nxt_vout;
			irq_n_ff <= nxt_irq_n;
		end
	end

	assign buck1_en = en_ff;
	assign buck1_vout_code = vout_ff;
	assign buck1_phase = ctrl_ff.phase;
	assign buck1_pwm_force = ctrl_ff.pwm_force;
	assign buck1_delay = ctrl_ff.delay;
	assign sysvolt_threshold = sysmon_ff.sysvolt_threshold;
	assign auto_shutdown = shut_ff;
	assign irq_n = irq_n_ff;
	assign reset_out_pin_n = rsto_n_ff;

	// Read views for checks; always_comb follows the state read inside the function
	logic [7:0] rd_sysmon, rd_sp1, rd_sp2;
	always_comb
	begin
		rd_sysmon = rd_byte(psb_pkg::ADDR_SYSMON);
		rd_sp1 = rd_byte(psb_pkg::ADDR_SP1);
		rd_sp2 = rd_byte(psb_pkg::ADDR_SP2);
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_pg_held;
		pg_s && !rsto_n_ff;
	endsequence
	sequence s_uvlo_seen;
		uvlo_s ##1 1'b1;
	endsequence

	AST_RST_SHORT: assert property (
		(s_pg_held and (sysmon_ff.short_rst_sel && tmr_ff == psb_pkg::TMR_W'(RST_SHORT_CYC - 1))) |=> reset_out_pin_n)
		else $error("short reset time-out missed");
	AST_RST_LONG: assert property (
		(s_pg_held and (!sysmon_ff.short_rst_sel && tmr_ff < psb_pkg::TMR_W'(RST_LONG_CYC - 1))) |=> !reset_out_pin_n)
		else $error("long reset time-out released early");
	AST_SHUTDOWN: assert property (low_s && !sysmon_ff.monitor_response_sel && !uvlo_s |=> auto_shutdown ##1 !buck1_en)
		else $error("low supply did not shut down converter");
	AST_MASKED: assert property (!sysmon_ff.sysvolt_irq_unmask && !(flt_s && ctrl_ff.fault_irq_unmask) |=> irq_n)
		else $error("masked interrupt reached output");
	AST_IRQ_SYS: assert property (low_s && sysmon_ff.monitor_response_sel && sysmon_ff.sysvolt_irq_unmask |=> !irq_n)
		else $error("unmasked supply interrupt missing");
	AST_IRQ_FLT: assert property (flt_s && ctrl_ff.fault_irq_unmask |=> !irq_n)
		else $error("unmasked fault interrupt missing");
	AST_STATUS: assert property (rd_sysmon[4] == low_s)
		else $error("status bit does not follow comparator");
	AST_FORCE_ON: assert property (ctrl_ff.on && hib_ff.buck1_force_on && !hold_s && !shut_ff |=> buck1_en)
		else $error("force-on did not hold converter");
	AST_UVLO: assert property (s_uvlo_seen |-> hib_ff == psb_pkg::HIB_RST)
		else $error("lockout did not clear user bits");
	AST_SETPOINT_SELECT_PIN: assert property (!setpoint_select_pin_s |=> buck1_vout_code == $past(sp1_ff))
		else $error("primary set point not selected");
	AST_VSEL2: assert property (setpoint_select_pin_s |=> buck1_vout_code == $past(sp2_ff))
		else $error("secondary set point not selected");
	AST_OFF: assert property (!ctrl_ff.on |=> !buck1_en)
		else $error("converter on while disabled");
	AST_RSV: assert property (rd_sp1[7:6] == 2'b00 && rd_sp2[7:6] == 2'b00)
		else $error("reserved set-point bits not zero");
endmodule : psb_regs

// [core/psb_pkg.sv]
/*
 Constants, register layouts and reset values for the system and first-buck
 register bank of the power-management controller.
 Assumes a 125 MHz system clock and a two-wire serial host.
*/
package psb_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned RST_SHORT_MS = 65;
	localparam int unsigned RST_LONG_MS = 260;
	localparam int unsigned TMR_W = 25;

	localparam logic [7:0] ADDR_SYSMON = 8'h00;
	localparam logic [7:0] ADDR_HIB = 8'h01;
	localparam logic [7:0] ADDR_SP1 = 8'h20;
	localparam logic [7:0] ADDR_SP2 = 8'h21;
	localparam logic [7:0] ADDR_CTRL = 8'h22;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] PTR_STEP = 8'h01;

	// Serial slave address, plain default
	localparam logic [6:0] DEV_ADDR_DFLT = 7'h5b;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_FULL = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_STEP = 4'h1;

	// Synchroniser lanes
	localparam int NSYNC = 8;
	localparam int SI_SCL = 0;
	localparam int SI_SDA = 1;
	localparam int SI_LOW = 2;
	localparam int SI_FLT = 3;
	localparam int SI_PG = 4;
	localparam int SI_SETPOINT_SELECT_PIN = 5;
	localparam int SI_HOLD = 6;
	localparam int SI_UVLO = 7;

	typedef struct packed {
		logic short_rst_sel;
		logic monitor_response_sel;
		logic sysvolt_irq_unmask;
		logic [3:0] sysvolt_threshold;
	} psb_sysmon_t;

	typedef struct packed {
		logic rsv7;
		logic buck1_force_on;
		logic [1:0] rsv54;
		logic [1:0] user_a;
		logic hibernate_ready_flag;
		logic user_b;
	} psb_hib_t;

	typedef struct packed {
		logic on;
		logic phase;
		logic pwm_force;
		logic [2:0] delay;
		logic fault_irq_unmask;
	} psb_ctrl_t;

	localparam psb_sysmon_t SYSMON_RST = 7'h00;
	localparam psb_hib_t HIB_RST = 8'h00;
	localparam logic [5:0] SP1_RST = 6'h24;
	localparam logic [5:0] SP2_RST = 6'h24;
	localparam psb_ctrl_t CTRL_RST = 7'h04;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_MACK = 3'b100
	} psb_state_t;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_PTR = 2'b01,
		PH_DATA = 2'b10
	} psb_phase_t;
endpackage : psb_pkg

// [test/psb_host.sv]
/*
 Host model: two-wire serial master that reaches the register bank.
 Assumes pull-ups on both lines; paced by the bench clock.
*/
`timescale 1ns/1ps
module psb_host (
	input wire logic clk_sys,
	input wire logic sda_oe,
	input wire logic sda_out,
	output logic scl,
	output logic sda
);
	logic pull;
	// Open drain wire, pull-up when nobody pulls
	assign sda = pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : hw
	// Data moves only while clock is low
	task automatic bt(input logic b, output logic r);
		pull = !b;
		hw(4);
		scl = 1'b1;
		hw(8);
		r = sda;
		scl = 1'b0;
		hw(4);
	endtask : bt
	task automatic st();
		pull = 1'b0;
		hw(4);
		scl = 1'b1;
		hw(8);
		pull = 1'b1;
		hw(8);
		scl = 1'b0;
		hw(4);
	endtask : st
	task automatic sp();
		pull = 1'b1;
		hw(4);
		scl = 1'b1;
		hw(8);
		pull = 1'b0;
		hw(8);
	endtask : sp
	task automatic by(input logic [7:0] d, input logic mk, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bt(d[i], r);
			q[i] = r;
		end
		bt(mk, r);
		ack = !r;
	endtask : by
	task automatic wr(input logic [6:0] da, input logic [7:0] p, input logic [7:0] d[$], output logic ok);
		logic [7:0] q;
		logic a;
		st();
		by({da, 1'b0}, 1'b1, q, ok);
		by(p, 1'b1, q, a);
		ok &= a;
		foreach (d[i])
		begin
			by(d[i], 1'b1, q, a);
			ok &= a;
		end
		sp();
	endtask : wr
	// Read of n bytes; master acknowledges all but the last
	task automatic rd(input logic [6:0] da, input logic [7:0] p, input int n, output logic [7:0] q[$]);
		logic [7:0] b;
		logic a;
		q = {};
		st();
		by({da, 1'b0}, 1'b1, b, a);
		by(p, 1'b1, b, a);
		st();
		by({da, 1'b1}, 1'b1, b, a);
		for (int i = 0; i < n; i++)
		begin
			by(8'hff, (i == n - 1), b, a);
			q.push_back(b);
		end
		sp();
	endtask : rd
endmodule : psb_host

// [test/pmu_system_and_buck1_regs_tb_top.sv]
/*
 Self-checking bench for the system and first-buck register bank.
 Assumes the host model on the serial pins and shortened reset counts.
*/
`timescale 1ns/1ps
module pmu_system_and_buck1_regs_tb_top;
	localparam int unsigned SHORT = 20;
	localparam int unsigned LONG = 50;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic low = 1'b0, flt = 1'b0, pg = 1'b0, sel = 1'b0, hold = 1'b0, uvlo = 1'b0;
	logic scl, sda, sda_oe, en, ph, pwm, shut, irq_n, rso_n, ok;
	logic [3:0] thr;
	logic [5:0] vout;
	logic [2:0] dly;
	logic sda_o;
	int n_mismatch = 0;
	int n_tests = 0;
	int rv [int];
	int wm [int];
	always #4 clk_sys = !clk_sys;
	psb_host host_u (.clk_sys(clk_sys), .sda_oe(sda_oe), .sda_out(sda_o), .scl(scl), .sda(sda));
	psb_regs #(.RST_SHORT_CYC(SHORT), .RST_LONG_CYC(LONG)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe), .sysvolt_low_in(low),
		.buck1_fault_in(flt), .buck1_pgood_in(pg), .setpoint_select_pin(sel), .power_hold_in(hold),
		.uvlo_in(uvlo), .sysvolt_threshold(thr), .buck1_en(en), .buck1_vout_code(vout),
		.buck1_phase(ph), .buck1_pwm_force(pwm), .buck1_delay(dly), .auto_shutdown(shut),
		.irq_n(irq_n), .reset_out_pin_n(rso_n));
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic m_rst();
		rv = '{0: 'h00, 1: 'h00, 'h20: 'h24, 'h21: 'h24, 'h22: 'h08};
		wm = '{0: 'hef, 1: 'hff, 'h20: 'h3f, 'h21: 'h3f, 'h22: 'hfe};
	endtask : m_rst
	// Live status bits join the stored ones
	function automatic logic [7:0] exp_rd(input int a);
		int v;
		v = rv.exists(a) ? rv[a] : 0;
		if (a == 0)
			v |= {low, 4'h0};
		if (a == 'h22)
			v |= pg;
		return v[7:0];
	endfunction : exp_rd
	task automatic mw(input int a, input logic [7:0] d[$]);
		host_u.wr(psb_pkg::DEV_ADDR_DFLT, a[7:0], d, ok);
		chk("write ack", 1, ok);
		foreach (d[i])
			if (wm.exists(a + i))
				rv[a + i] = d[i] & wm[a + i];
	endtask : mw
	task automatic mr(input int a, input int n = 1);
		logic [7:0] qq[$];
		host_u.rd(psb_pkg::DEV_ADDR_DFLT, a[7:0], n, qq);
		foreach (qq[i])
			chk($sformatf("reg %h", a + i), exp_rd(a + i), qq[i]);
	endtask : mr
	task automatic pins();
		logic [7:0] c;
		c = rv['h22];
		step(8);
		chk("ctrl pins", {c[6:2], 6'(sel ? rv['h21] : rv['h20]), 4'(rv[0])}, {ph, pwm, dly, vout, thr});
	endtask : pins
	initial
	begin
		void'($urandom(32'ha0471236));
		m_rst();
		step(2);
		rst = 1'b0;
		step(10);
		foreach (wm[a])
			mr(a);
		mr('h33);
		host_u.wr(psb_pkg::DEV_ADDR_DFLT ^ 7'h01, 8'h20, '{8'h00}, ok);
		chk("foreign ack", 0, ok);
		repeat (3)
		begin
			sel = !sel;
			foreach (wm[a])
				mw(a, '{8'($urandom)});
			mw('h33, '{8'hff});
			mw('h20, '{8'($urandom), 8'($urandom)});
			foreach (wm[a])
				mr(a);
			mr('h33);
			mr('h20, 3);
			pins();
		end
		mw(1, '{8'h00});
		mw('h22, '{8'h80});
		hold = 1'b1;
		step(8);
		chk("en", 1, en);
		hold = 1'b0;
		step(8);
		chk("en", 0, en);
		// Host arms hibernate, then reads the flag back
		mw(1, '{8'h42});
		mr(1);
		chk("en", 1, en);
		mw('h22, '{8'h00});
		step(2);
		chk("en", 0, en);
		mw(0, '{8'h60});
		low = 1'b1;
		step(8);
		chk("irq", 0, irq_n);
		chk("shut", 0, shut);
		mr(0);
		mw(0, '{8'h40});
		step(2);
		chk("irq", 1, irq_n);
		mw('h22, '{8'h02});
		flt = 1'b1;
		step(8);
		chk("irq", 0, irq_n);
		mw('h22, '{8'h80});
		step(2);
		chk("irq", 1, irq_n);
		flt = 1'b0;
		mw(0, '{8'h00});
		step(8);
		chk("shut", 1, shut);
		chk("en", 0, en);
		rst = 1'b1;
		low = 1'b0;
		step(2);
		rst = 1'b0;
		m_rst();
		step(10);
		mw(0, '{8'h80});
		pg = 1'b1;
		step(SHORT - 2);
		chk("rso", 0, rso_n);
		step(14);
		chk("rso", 1, rso_n);
		mr('h22);
		pg = 1'b0;
		mw(0, '{8'h00});
		pg = 1'b1;
		step(SHORT + 12);
		chk("rso", 0, rso_n);
		step(LONG - SHORT);
		chk("rso", 1, rso_n);
		mw(1, '{8'h0d});
		uvlo = 1'b1;
		step(8);
		uvlo = 1'b0;
		step(8);
		m_rst();
		foreach (wm[a])
			mr(a);
		end_of_test();
	end
	// Run needs about 40k cycles
	initial
	begin
		step(90000);
		n_mismatch++;
		end_of_test();
	end
endmodule : pmu_system_and_buck1_regs_tb_top
